/* nct_regs.vh */
`ifndef NCT_REGS_VH
`define NCT_REGS_VH

// register bus offsets (byte addresses)
`define NCT_ADDR_W 8
`define NCT_OFF_CTRL 8'h00
`define NCT_OFF_ACC 8'h04
`define NCT_OFF_PC 8'h08
`define NCT_OFF_STAT 8'h0C

// control register fields
`define NCT_CTRL_RUN 0
`define NCT_CTRL_PAGE_LO 1
`define NCT_CTRL_PAGE_HI 2

// status register fields
`define NCT_STAT_SP 0
`define NCT_STAT_IRST 4

// reset values
`define NCT_RST_PC 11'h000
`define NCT_RST_ACC 4'h0
`define NCT_RST_PAGE 2'h0
`define NCT_RST_PORT 4'h0

// widths
`define NCT_PC_W 11
`define NCT_WORD_W 10

// instruction words, exact or under a mask
`define NCT_MSK_XRLP 10'h3D8
`define NCT_VAL_XRLP 10'h298
`define NCT_MSK_OUTI 10'h3F8
`define NCT_VAL_OUTI 10'h0D0
`define NCT_MSK_MOVAR 10'h3D0
`define NCT_VAL_MOVAR 10'h3C0
`define NCT_MSK_MOVRA 10'h3D0
`define NCT_VAL_MOVRA 10'h080
`define NCT_MSK_MOVRI 10'h3F0
`define NCT_VAL_MOVRI 10'h1C0
`define NCT_MSK_MOVRT 10'h3F0
`define NCT_VAL_MOVRT 10'h1E0
`define NCT_OP_MOVA_TH 10'h3D0
`define NCT_OP_MOVA_TL 10'h3F0
`define NCT_OP_MOVA_IMM 10'h3F1
`define NCT_OP_MOVA_T1 10'h3BF
`define NCT_OP_MOVA_T0 10'h39F
`define NCT_OP_JMP_P0 10'h011
`define NCT_OP_JMP_P1 10'h031
`define NCT_OP_CALL_P0 10'h051
`define NCT_OP_CALL_P1 10'h071
`define NCT_OP_JC_P0 10'h191
`define NCT_OP_JC_P1 10'h151
`define NCT_OP_JNC_P0 10'h1B1
`define NCT_OP_JNC_P1 10'h171
`define NCT_OP_JF_P0 10'h1D1
`define NCT_OP_JF_P1 10'h211
`define NCT_OP_JNF_P0 10'h1F1
`define NCT_OP_JNF_P1 10'h231
`define NCT_OP_RET 10'h112

`endif

/* nct_regfile.v */
`timescale 1ns/1ns
`include "nct_regs.vh"

// ----------------------------------------
// two banks of sixteen nibble registers
// ----------------------------------------
module nct_regfile
(
    input wire sys_clk_in,
    input wire rstn_in,
    input wire clr_in,
    input wire we_in,
    input wire [4:0] waddr_in,
    input wire [3:0] wdata_in,
    input wire pwe_in,
    input wire [3:0] pidx_in,
    input wire [7:0] pdata_in,
    input wire [4:0] raddr_in,
    output wire [3:0] rdata_out,
    output wire [7:0] pair0_out
);

wire [3:0] nib_w [0:31];

assign rdata_out = nib_w[raddr_in];
assign pair0_out = {nib_w[16], nib_w[0]};

genvar g;
generate
    for (g = 0; g < 32; g = g + 1)
    begin : g_nib
        reg [3:0] nib_ff;
        assign nib_w[g] = nib_ff;
        always @(posedge sys_clk_in or negedge rstn_in)
        begin
            if (!rstn_in)
                nib_ff <= 4'h0;
            else if (clr_in)
                nib_ff <= 4'h0;
            else if (pwe_in && ({1'b1, pidx_in} == g))
                nib_ff <= pdata_in[7:4];
            else if (pwe_in && ({1'b0, pidx_in} == g))
                nib_ff <= pdata_in[3:0];
            else if (we_in && (waddr_in == g))
                nib_ff <= wdata_in;
        end
    end
endgenerate

endmodule

/* nct_core.v */
// Local design decisions: strobed register access and the register offsets.
`timescale 1ns/1ns
`include "nct_regs.vh"
module nct_core #(
    parameter PAGE_COUNT = 2,
    parameter SP_WIDTH = 1
)
(
    input wire sys_clk_in,
    input wire rstn_in,
    input wire [`NCT_ADDR_W-1:0] bus_addr_in,
    input wire [31:0] bus_wdata_in,
    input wire bus_wr_in,
    input wire bus_rd_in,
    output reg [31:0] bus_rdata_out,
    input wire [9:0] rom_data_in,
    input wire test_flag_in,
    input wire [9:0] timer_in,
    output wire [10:0] rom_addr_out,
    output wire [31:0] port_latch_out,
    output wire [3:0] acc_out,
    output wire carry_bit_out,
    output wire int_reset_out
);

// ----------------------------------------
// states and helpers
// ----------------------------------------
localparam S_ISSUE = 4'b0001;
localparam S_EXEC = 4'b0010;
localparam S_OPND = 4'b0100;
localparam S_TABLE = 4'b1000;

// bit 2 valid, bits 1:0 latch slot for port index 0, 1, 3, 4
function [2:0] port_slot;
    input [2:0] n;
    begin
        case (n)
            3'h0: port_slot = 3'b100;
            3'h1: port_slot = 3'b101;
            3'h3: port_slot = 3'b110;
            3'h4: port_slot = 3'b111;
            default: port_slot = 3'b000;
        endcase
    end
endfunction

// address word carries a9 a7..a4 a8 a3..a0
function [9:0] addr_field;
    input [9:0] w;
    begin
        addr_field = {w[9], w[4], w[8:5], w[3:0]};
    end
endfunction

// byte word carries 0 d7..d4 0 d3..d0
function [7:0] byte_field;
    input [9:0] w;
    begin
        byte_field = {w[8:5], w[3:0]};
    end
endfunction

// ----------------------------------------
// state
// ----------------------------------------
reg [3:0] state_ff;
reg [10:0] pc_ff;
reg [SP_WIDTH-1:0] stack_depth_pointer_ff;
reg [10:0] saved_return_reg_ff;
reg [3:0] acc_ff;
reg carry_bit_ff;
reg [9:0] instr_ff;
reg [10:0] rom_addr_ff;
reg [3:0] port_ff [0:7];
reg run_ff;
reg [1:0] rom_page_select_ff;
reg int_reset_ff;
reg irst_seen_ff;

reg [3:0] nxt_state;
reg [10:0] nxt_pc;
reg [SP_WIDTH-1:0] nxt_sp;
reg [10:0] nxt_ret;
reg [3:0] nxt_acc;
reg nxt_carry;
reg [9:0] nxt_instr;
reg [10:0] nxt_rom_addr;
reg do_irst;
reg port_we;
reg port_pair;
reg [2:0] port_sel;
reg [7:0] port_data;
reg rf_we;
reg [4:0] rf_waddr;
reg [3:0] rf_wdata;
reg rf_pwe;
reg [3:0] rf_pidx;
reg [7:0] rf_pdata;

wire [3:0] rf_rdata;
wire [7:0] rf_pair0;
wire [9:0] iw;
wire [2:0] xslot;
wire [3:0] xport;
wire op_jmp;
wire op_call;
wire op_jc;
wire op_jnc;
wire op_jf;
wire op_jnf;
wire op_pg1;
wire [10:0] pc_next1;
wire [10:0] pc_next2;
wire [10:0] br_target;
wire [SP_WIDTH-1:0] sp_inc;
wire sp_carry;
wire [SP_WIDTH-1:0] sp_dec;
wire sp_borrow;

assign iw = instr_ff;
assign xslot = port_slot(rom_data_in[2:0]);
assign xport = port_ff[{rom_data_in[5], xslot[1:0]}];
assign op_jmp = (iw == `NCT_OP_JMP_P0) || (iw == `NCT_OP_JMP_P1);
assign op_call = (iw == `NCT_OP_CALL_P0) || (iw == `NCT_OP_CALL_P1);
assign op_jc = (iw == `NCT_OP_JC_P0) || (iw == `NCT_OP_JC_P1);
assign op_jnc = (iw == `NCT_OP_JNC_P0) || (iw == `NCT_OP_JNC_P1);
assign op_jf = (iw == `NCT_OP_JF_P0) || (iw == `NCT_OP_JF_P1);
assign op_jnf = (iw == `NCT_OP_JNF_P0) || (iw == `NCT_OP_JNF_P1);
assign op_pg1 = (iw == `NCT_OP_JMP_P1) || (iw == `NCT_OP_CALL_P1) ||
    (iw == `NCT_OP_JC_P1) || (iw == `NCT_OP_JNC_P1) ||
    (iw == `NCT_OP_JF_P1) || (iw == `NCT_OP_JNF_P1);
// counting stays inside the current 1K page
assign pc_next1 = {pc_ff[10], pc_ff[9:0] + 10'h001};
assign pc_next2 = {pc_ff[10], pc_ff[9:0] + 10'h002};
// second page only exists on the larger product
assign br_target = {op_pg1 & (PAGE_COUNT > 1),
    addr_field(rom_data_in)};
assign {sp_carry, sp_inc} = {1'b0, stack_depth_pointer_ff} + 1'b1;
assign {sp_borrow, sp_dec} = {1'b0, stack_depth_pointer_ff} - 1'b1;

// ----------------------------------------
// decode and execute
// ----------------------------------------
always @*
begin
    nxt_state = state_ff;
    nxt_pc = pc_ff;
    nxt_sp = stack_depth_pointer_ff;
    nxt_ret = saved_return_reg_ff;
    nxt_acc = acc_ff;
    nxt_carry = carry_bit_ff;
    nxt_instr = instr_ff;
    nxt_rom_addr = rom_addr_ff;
    do_irst = 1'b0;
    port_we = 1'b0;
    port_pair = 1'b0;
    port_sel = 3'h0;
    port_data = 8'h00;
    rf_we = 1'b0;
    rf_waddr = 5'h00;
    rf_wdata = 4'h0;
    rf_pwe = 1'b0;
    rf_pidx = 4'h0;
    rf_pdata = 8'h00;
    case (state_ff)
        S_ISSUE:
        begin
            nxt_rom_addr = pc_ff;
            if (run_ff)
                nxt_state = S_EXEC;
        end
        S_EXEC:
        begin
            nxt_instr = rom_data_in;
            nxt_pc = pc_next1;
            nxt_state = S_EXEC;
            if ((rom_data_in & `NCT_MSK_XRLP) == `NCT_VAL_XRLP)
            begin
                if (xslot[2])
                begin
                    nxt_acc = acc_ff ^ xport;
                    nxt_carry = acc_ff[3] & xport[3];
                end
            end
            else if ((rom_data_in & `NCT_MSK_MOVAR) == `NCT_VAL_MOVAR)
            begin
                nxt_acc = rf_rdata;
                nxt_carry = 1'b0;
            end
            else if ((rom_data_in & `NCT_MSK_MOVRA) == `NCT_VAL_MOVRA)
            begin
                rf_we = 1'b1;
                rf_waddr = {rom_data_in[5], rom_data_in[3:0]};
                rf_wdata = acc_ff;
            end
            else if (rom_data_in == `NCT_OP_MOVA_T1)
                nxt_acc = timer_in[9:6];
            else if (rom_data_in == `NCT_OP_MOVA_T0)
                nxt_acc = timer_in[5:2];
            else if (rom_data_in == `NCT_OP_RET)
            begin
                nxt_pc = saved_return_reg_ff;
                nxt_sp = sp_dec;
                do_irst = sp_borrow;
            end
            else if ((rom_data_in == `NCT_OP_MOVA_TH) ||
                (rom_data_in == `NCT_OP_MOVA_TL) ||
                ((rom_data_in & `NCT_MSK_MOVRT) == `NCT_VAL_MOVRT))
            begin
                nxt_pc = pc_ff;
                nxt_rom_addr = {pc_ff[10], rom_page_select_ff,
                    rf_pair0};
                nxt_state = S_TABLE;
            end
            else if ((rom_data_in == `NCT_OP_MOVA_IMM) ||
                ((rom_data_in & `NCT_MSK_OUTI) == `NCT_VAL_OUTI) ||
                ((rom_data_in & `NCT_MSK_MOVRI) == `NCT_VAL_MOVRI) ||
                (rom_data_in == `NCT_OP_JMP_P0) ||
                (rom_data_in == `NCT_OP_JMP_P1) ||
                (rom_data_in == `NCT_OP_CALL_P0) ||
                (rom_data_in == `NCT_OP_CALL_P1) ||
                (rom_data_in == `NCT_OP_JC_P0) ||
                (rom_data_in == `NCT_OP_JC_P1) ||
                (rom_data_in == `NCT_OP_JNC_P0) ||
                (rom_data_in == `NCT_OP_JNC_P1) ||
                (rom_data_in == `NCT_OP_JF_P0) ||
                (rom_data_in == `NCT_OP_JF_P1) ||
                (rom_data_in == `NCT_OP_JNF_P0) ||
                (rom_data_in == `NCT_OP_JNF_P1))
            begin
                nxt_pc = pc_ff;
                nxt_rom_addr = pc_next1;
                nxt_state = S_OPND;
            end
            if (nxt_state == S_EXEC)
            begin
                nxt_rom_addr = nxt_pc;
                if (!run_ff)
                    nxt_state = S_ISSUE;
            end
        end
        S_OPND:
        begin
            nxt_pc = pc_next2;
            if (iw == `NCT_OP_MOVA_IMM)
            begin
                nxt_acc = rom_data_in[3:0];
                nxt_carry = 1'b0;
            end
            else if ((iw & `NCT_MSK_OUTI) == `NCT_VAL_OUTI)
            begin
                port_sel = port_slot(iw[2:0]);
                port_we = port_sel[2];
                port_pair = 1'b1;
                port_data = byte_field(rom_data_in);
            end
            else if ((iw & `NCT_MSK_MOVRI) == `NCT_VAL_MOVRI)
            begin
                rf_pwe = 1'b1;
                rf_pidx = iw[3:0];
                rf_pdata = byte_field(rom_data_in);
            end
            else if (op_jmp)
                nxt_pc = br_target;
            else if (op_jc && carry_bit_ff)
                nxt_pc = br_target;
            else if (op_jnc && !carry_bit_ff)
                nxt_pc = br_target;
            else if (op_jf && test_flag_in)
                nxt_pc = br_target;
            else if (op_jnf && !test_flag_in)
                nxt_pc = br_target;
            else if (op_call)
            begin
                nxt_sp = sp_inc;
                nxt_ret = pc_next2;
                nxt_pc = br_target;
                do_irst = sp_carry;
            end
            nxt_rom_addr = nxt_pc;
            nxt_state = run_ff ? S_EXEC : S_ISSUE;
        end
        S_TABLE:
        begin
            nxt_pc = pc_next1;
            if (iw == `NCT_OP_MOVA_TH)
            begin
                nxt_acc = rom_data_in[7:4];
                nxt_carry = 1'b0;
            end
            else if (iw == `NCT_OP_MOVA_TL)
            begin
                nxt_acc = rom_data_in[3:0];
                nxt_carry = 1'b0;
            end
            else
            begin
                rf_pwe = 1'b1;
                rf_pidx = iw[3:0];
                rf_pdata = rom_data_in[7:0];
            end
            nxt_rom_addr = nxt_pc;
            nxt_state = run_ff ? S_EXEC : S_ISSUE;
        end
        default:
        begin
            nxt_state = S_ISSUE;
        end
    endcase
end

// ----------------------------------------
// core registers
// ----------------------------------------
integer i;
always @(posedge sys_clk_in or negedge rstn_in)
begin
    if (!rstn_in)
    begin
        state_ff <= S_ISSUE;
        pc_ff <= `NCT_RST_PC;
        stack_depth_pointer_ff <= {SP_WIDTH{1'b0}};
        saved_return_reg_ff <= `NCT_RST_PC;
        acc_ff <= `NCT_RST_ACC;
        carry_bit_ff <= 1'b0;
        instr_ff <= 10'h000;
        rom_addr_ff <= `NCT_RST_PC;
        rom_page_select_ff <= `NCT_RST_PAGE;
        int_reset_ff <= 1'b0;
        for (i = 0; i < 8; i = i + 1)
            port_ff[i] <= `NCT_RST_PORT;
    end
    else if (do_irst)
    begin
        state_ff <= S_ISSUE;
        pc_ff <= `NCT_RST_PC;
        stack_depth_pointer_ff <= {SP_WIDTH{1'b0}};
        saved_return_reg_ff <= `NCT_RST_PC;
        acc_ff <= `NCT_RST_ACC;
        carry_bit_ff <= 1'b0;
        instr_ff <= 10'h000;
        rom_addr_ff <= `NCT_RST_PC;
        rom_page_select_ff <= `NCT_RST_PAGE;
        int_reset_ff <= 1'b1;
        for (i = 0; i < 8; i = i + 1)
            port_ff[i] <= `NCT_RST_PORT;
    end
    else
    begin
        state_ff <= nxt_state;
        pc_ff <= nxt_pc;
        stack_depth_pointer_ff <= nxt_sp;
        saved_return_reg_ff <= nxt_ret;
        acc_ff <= nxt_acc;
        carry_bit_ff <= nxt_carry;
        instr_ff <= nxt_instr;
        rom_addr_ff <= nxt_rom_addr;
        int_reset_ff <= 1'b0;
        if (bus_wr_in && (bus_addr_in == `NCT_OFF_CTRL))
            rom_page_select_ff <=
                bus_wdata_in[`NCT_CTRL_PAGE_HI:`NCT_CTRL_PAGE_LO];
        if (port_we && port_pair)
        begin
            port_ff[{1'b1, port_sel[1:0]}] <= port_data[7:4];
            port_ff[{1'b0, port_sel[1:0]}] <= port_data[3:0];
        end
    end
end

// ----------------------------------------
// register bus
// ----------------------------------------
always @(posedge sys_clk_in or negedge rstn_in)
begin
    if (!rstn_in)
    begin
        run_ff <= 1'b0;
        irst_seen_ff <= 1'b0;
        bus_rdata_out <= 32'h0000_0000;
    end
    else
    begin
        if (bus_wr_in && (bus_addr_in == `NCT_OFF_CTRL))
            run_ff <= bus_wdata_in[`NCT_CTRL_RUN];
        // a new internal reset wins over a clear in the same cycle
        if (do_irst)
            irst_seen_ff <= 1'b1;
        else if (bus_wr_in && (bus_addr_in == `NCT_OFF_STAT) &&
            bus_wdata_in[`NCT_STAT_IRST])
            irst_seen_ff <= 1'b0;
        bus_rdata_out <= 32'h0000_0000;
        if (bus_rd_in)
        begin
            case (bus_addr_in)
                `NCT_OFF_CTRL:
                    bus_rdata_out <= {29'h0, rom_page_select_ff, run_ff};
                `NCT_OFF_ACC:
                    bus_rdata_out <= {27'h0, carry_bit_ff, acc_ff};
                `NCT_OFF_PC:
                    bus_rdata_out <= {21'h0, pc_ff};
                `NCT_OFF_STAT:
                    bus_rdata_out <= {27'h0, irst_seen_ff,
                        {(4-SP_WIDTH){1'b0}}, stack_depth_pointer_ff};
                default:
                    bus_rdata_out <= 32'h0000_0000;
            endcase
        end
    end
end

// ----------------------------------------
// outputs and register file
// ----------------------------------------
assign rom_addr_out = rom_addr_ff;
assign acc_out = acc_ff;
assign carry_bit_out = carry_bit_ff;
assign int_reset_out = int_reset_ff;

genvar g;
generate
    for (g = 0; g < 8; g = g + 1)
    begin : g_port
        assign port_latch_out[g*4+3:g*4] = port_ff[g];
    end
endgenerate

nct_regfile u_regfile
(
    .sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .clr_in(do_irst),
    .we_in(rf_we),
    .waddr_in(rf_waddr),
    .wdata_in(rf_wdata),
    .pwe_in(rf_pwe),
    .pidx_in(rf_pidx),
    .pdata_in(rf_pdata),
    .raddr_in({rom_data_in[5], rom_data_in[3:0]}),
    .rdata_out(rf_rdata),
    .pair0_out(rf_pair0)
);

endmodule

/* nct_core_props.sv */
`timescale 1ns/1ns
`include "nct_regs.vh"
module nct_core_props #(
    parameter PAGE_COUNT = 2,
    parameter SP_WIDTH = 1
)
(
    input wire sys_clk_in,
    input wire rstn_in,
    input wire [`NCT_ADDR_W-1:0] bus_addr_in,
    input wire [31:0] bus_wdata_in,
    input wire bus_wr_in,
    input wire bus_rd_in,
    input wire [31:0] bus_rdata_out,
    input wire [9:0] rom_data_in,
    input wire test_flag_in,
    input wire [9:0] timer_in,
    input wire [10:0] rom_addr_out,
    input wire [31:0] port_latch_out,
    input wire [3:0] acc_out,
    input wire carry_bit_out,
    input wire int_reset_out
);
    reg [10:0] prev_addr_ff;
    wire adv = rom_addr_out == prev_addr_ff + 11'h001;
    wire [3:0] t_hi = timer_in[9:6];
    wire [3:0] t_lo = timer_in[5:2];

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    always @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            prev_addr_ff <= 11'h000;
        else
            prev_addr_ff <= rom_addr_out;
    end

    function [4:0] xr(input [3:0] a, input [31:0] p, input [9:0] w);
        reg [1:0] s;
        reg [3:0] n;
        begin
            s = (w[2:0] == 3'h4) ? 2'h3 : (w[2:0] == 3'h3) ? 2'h2 : w[1:0];
            n = p[{w[5], s, 2'h0} +: 4];
            xr = {a[3] & n[3], a ^ n};
        end
    endfunction

    function okp(input [9:0] w);
        okp = w[2:0] == 3'h0 || w[2:0] == 3'h1 || w[2:0] == 3'h3
            || w[2:0] == 3'h4;
    endfunction

    function [9:0] ad(input [9:0] w);
        ad = {w[9], w[4], w[8:5], w[3:0]};
    endfunction

    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rstn_in);

    rdata_idle_a: assert property (!$past(bus_rd_in)
        |-> bus_rdata_out == 32'h0)
        else $error("read data not zero outside read slot");
    acc_read_a: assert property ($past(bus_rd_in)
        && $past(bus_addr_in) == `NCT_OFF_ACC |-> bus_rdata_out
        == {27'h0, $past(carry_bit_out), $past(acc_out)})
        else $error("accumulator read data wrong");
    irst_pulse_a: assert property (int_reset_out |=> !int_reset_out)
        else $error("internal reset pulse too long");
    irst_state_a: assert property (int_reset_out |->
        port_latch_out == 32'h0 && acc_out == 4'h0 && !carry_bit_out
        && rom_addr_out == 11'h000)
        else $error("state not cleared by internal reset");
    xor_port_a: assert property (adv && okp($past(rom_data_in))
        && ($past(rom_data_in) & `NCT_MSK_XRLP) == `NCT_VAL_XRLP
        |-> {carry_bit_out, acc_out} == xr($past(acc_out),
        $past(port_latch_out), $past(rom_data_in)))
        else $error("port xor result wrong");
    mova_reg_a: assert property (adv
        && ($past(rom_data_in) & `NCT_MSK_MOVAR) == `NCT_VAL_MOVAR
        |-> !carry_bit_out)
        else $error("carry not cleared by register load");
    timer_hi_a: assert property (adv
        && $past(rom_data_in) == `NCT_OP_MOVA_T1 |-> acc_out == $past(t_hi))
        else $error("timer high nibble wrong");
    timer_lo_a: assert property (adv
        && $past(rom_data_in) == `NCT_OP_MOVA_T0 |-> acc_out == $past(t_lo))
        else $error("timer low nibble wrong");
    jc_skip_a: assert property ((rom_data_in == `NCT_OP_JC_P0
        && !carry_bit_out) ##1 adv |=> adv)
        else $error("branch on carry did not skip");
    jnc_take_a: assert property ((rom_data_in == `NCT_OP_JNC_P0
        && !carry_bit_out) ##1 adv |=> rom_addr_out
        == {1'b0, ad($past(rom_data_in))})
        else $error("branch on no carry missed target");

    cover property (int_reset_out);
    cover property ($past(bus_rd_in) && $past(bus_addr_in) == `NCT_OFF_STAT);
    cover property ((rom_data_in == `NCT_OP_JC_P0 && carry_bit_out) ##1 adv);
endmodule

/* tb_nct_core.sv */
`timescale 1ns/1ns
`include "nct_regs.vh"
module tb_nct_core;
    logic sys_clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic [7:0] bus_addr_in = 8'h00;
    logic [31:0] bus_wdata_in = 32'h0;
    logic bus_wr_in = 1'b0;
    logic bus_rd_in = 1'b0;
    logic test_flag_in = 1'b0;
    logic [9:0] timer_in = 10'h2D9;
    wire [31:0] bus_rdata_out;
    wire [9:0] rom_data_in;
    wire [10:0] rom_addr_out;
    wire [31:0] port_latch_out;
    wire [3:0] acc_out;
    wire carry_bit_out;
    wire int_reset_out;
    logic [9:0] rom_mem [0:2047];
    logic saw_tab = 1'b0;
    int n_mismatch = 0;
    int tests_run = 0;
    int cyc = 0;

    // rom answers within the same cycle
    assign rom_data_in = rom_mem[rom_addr_out];

    nct_core #(.PAGE_COUNT(2), .SP_WIDTH(1)) u_nct_core (
        .sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
        .bus_addr_in(bus_addr_in), .bus_wdata_in(bus_wdata_in),
        .bus_wr_in(bus_wr_in), .bus_rd_in(bus_rd_in),
        .bus_rdata_out(bus_rdata_out), .rom_data_in(rom_data_in),
        .test_flag_in(test_flag_in), .timer_in(timer_in),
        .rom_addr_out(rom_addr_out), .port_latch_out(port_latch_out),
        .acc_out(acc_out), .carry_bit_out(carry_bit_out),
        .int_reset_out(int_reset_out));

    initial
    begin
        forever #50 sys_clk_in = ~sys_clk_in;
    end

    always @(posedge sys_clk_in)
    begin
        cyc++;
        if (rom_addr_out === 11'h145)
            saw_tab <= 1'b1;
        if (cyc == 20000)
        begin
            n_mismatch++;
            final_report;
        end
    end

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task final_report;
        $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_in);
        bus_addr_in <= a;
        bus_wdata_in <= d;
        bus_wr_in <= 1'b1;
        @(posedge sys_clk_in);
        bus_wr_in <= 1'b0;
    endtask

    task bus_rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge sys_clk_in);
        bus_addr_in <= a;
        bus_rd_in <= 1'b1;
        @(posedge sys_clk_in);
        bus_rd_in <= 1'b0;
        @(negedge sys_clk_in);
        chk(bus_rdata_out, e);
    endtask

    task load(input int b, input logic [9:0] w[]);
        foreach (w[i])
            rom_mem[b + i] = w[i];
    endtask

    function logic [9:0] aw(input logic [9:0] a);
        return {a[9], a[7:4], a[8], a[3:0]};
    endfunction

    // reset, jump to base, then run with the given control value
    task start(input logic [10:0] base, input logic [31:0] ctrl);
        rom_mem[0] = 10'h011;
        rom_mem[1] = aw(base[9:0]);
        @(posedge sys_clk_in);
        rstn_in <= 1'b0;
        repeat (2) @(posedge sys_clk_in);
        rstn_in <= 1'b1;
        bus_wr(`NCT_OFF_CTRL, ctrl);
    endtask

    task wait_pc(input logic [10:0] a);
        int i;
        for (i = 0; i < 300; i++)
        begin
            @(negedge sys_clk_in);
            if (rom_addr_out === a)
                break;
        end
        chk({21'h0, rom_addr_out}, {21'h0, a});
    endtask

    task step(input logic [10:0] a, input logic [4:0] e);
        wait_pc(a);
        chk({27'h0, carry_bit_out, acc_out}, {27'h0, e});
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task test_regs;
        bus_rd(`NCT_OFF_CTRL, 32'h0);
        bus_rd(`NCT_OFF_ACC, 32'h0);
        bus_rd(`NCT_OFF_PC, 32'h0);
        bus_rd(`NCT_OFF_STAT, 32'h0);
        bus_wr(8'h10, 32'hFFFF_FFFF);
        bus_rd(8'h10, 32'h0);
        bus_wr(`NCT_OFF_CTRL, 32'h6);
        bus_rd(`NCT_OFF_CTRL, 32'h6);
        bus_wr(`NCT_OFF_CTRL, 32'h0);
        $display("register test done");
    endtask

    task test_xfer;
        load(32, '{10'h0D0, 10'h12C, 10'h3F1, 10'h00B, 10'h2B8, 10'h1C0,
            10'h085, 10'h3D0, 10'h298, 10'h3F0, 10'h298, 10'h0A3, 10'h2B8,
            10'h3E3, 10'h1E2, 10'h3C2, 10'h3E2, 10'h0D3, 10'h0EE, 10'h3BF,
            10'h39F, 10'h011, 10'h065});
        rom_mem[11'h145] = 10'h3A5;
        start(11'h020, 32'h3);
        step(11'h024, 5'h0B);
        step(11'h025, 5'h12);
        step(11'h028, 5'h0A);
        step(11'h029, 5'h16);
        step(11'h02A, 5'h05);
        step(11'h02B, 5'h09);
        step(11'h02D, 5'h10);
        step(11'h02E, 5'h09);
        step(11'h030, 5'h05);
        step(11'h031, 5'h0A);
        wait_pc(11'h033);
        chk(port_latch_out, 32'h0709_0E0C);
        step(11'h034, 5'h0B);
        step(11'h035, 5'h06);
        chk({31'h0, saw_tab}, 32'h1);
        $display("transfer test done");
    endtask

    task test_branch(input logic f);
        @(posedge sys_clk_in);
        test_flag_in <= f;
        load(256, '{10'h191, 10'h1F0, 10'h1B1, 10'h018, 10'h000, 10'h000,
            10'h000, 10'h000, 10'h1D1, 10'h01C, 10'h1F1, 10'h01E, 10'h1F1,
            10'h1F0, 10'h0D0, 10'h008, 10'h3F1, 10'h008, 10'h298, 10'h191,
            10'h038, 10'h000, 10'h000, 10'h000, 10'h1B1, 10'h1F0, 10'h051,
            10'h070, 10'h031, 10'h03C});
        load(304, '{10'h3F1, 10'h003, 10'h3F1, 10'h003, 10'h3F1, 10'h003,
            10'h3F1, 10'h003, 10'h112});
        load(496, '{10'h011, 10'h1F0});
        load(1308, '{10'h031, 10'h03C});
        start(11'h100, 32'h1);
        wait_pc(11'h102);
        wait_pc(11'h108);
        wait_pc(f ? 11'h10C : 11'h10A);
        wait_pc(11'h10E);
        wait_pc(11'h118);
        wait_pc(11'h11A);
        wait_pc(11'h130);
        bus_rd(`NCT_OFF_STAT, 32'h1);
        wait_pc(11'h11C);
        bus_rd(`NCT_OFF_STAT, 32'h0);
        chk({28'h0, acc_out}, 32'h3);
        wait_pc(11'h51C);
        $display("branch test done");
    endtask

    task test_irst(input logic [10:0] base);
        int i;
        start(base, 32'h1);
        for (i = 0; i < 300 && int_reset_out !== 1'b1; i++)
            @(negedge sys_clk_in);
        chk({31'h0, int_reset_out}, 32'h1);
        chk(port_latch_out, 32'h0);
        chk({27'h0, carry_bit_out, acc_out}, 32'h0);
        bus_wr(`NCT_OFF_CTRL, 32'h0);
        bus_rd(`NCT_OFF_STAT, 32'h10);
        bus_wr(`NCT_OFF_STAT, 32'h10);
        bus_rd(`NCT_OFF_STAT, 32'h0);
        $display("internal reset test done");
    endtask

    initial
    begin
        for (int i = 0; i < 2048; i++)
            rom_mem[i] = 10'h000;
        load(384, '{10'h0D0, 10'h0A5, 10'h3F1, 10'h007, 10'h051, 10'h118,
            10'h000, 10'h000, 10'h051, 10'h11A});
        load(416, '{10'h3F1, 10'h007, 10'h112});
        repeat (20) @(posedge sys_clk_in);
        rstn_in <= 1'b1;
        test_regs;
        test_xfer;
        test_branch(1'b1);
        test_branch(1'b0);
        test_irst(11'h180);
        test_irst(11'h1A0);
        final_report;
    end
endmodule

bind nct_core nct_core_props #(.PAGE_COUNT(PAGE_COUNT),
    .SP_WIDTH(SP_WIDTH)) u_nct_core_props (
    .sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
    .bus_addr_in(bus_addr_in), .bus_wdata_in(bus_wdata_in),
    .bus_wr_in(bus_wr_in), .bus_rd_in(bus_rd_in),
    .bus_rdata_out(bus_rdata_out), .rom_data_in(rom_data_in),
    .test_flag_in(test_flag_in), .timer_in(timer_in),
    .rom_addr_out(rom_addr_out), .port_latch_out(port_latch_out),
    .acc_out(acc_out), .carry_bit_out(carry_bit_out),
    .int_reset_out(int_reset_out));
